/* src/cbte_consts.vh */
// Purpose: Constants for the bit, flag and data-transfer execution unit.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, 40 MHz core clock.
// Notes: Opcodes are the values software writes to the command field.
`ifndef CBTE_CONSTS_VH
`define CBTE_CONSTS_VH

// ****************************************************************
// Register offsets and reset values
// ****************************************************************
`define CBTE_OFF_CMD      8'h00
`define CBTE_OFF_OPND     8'h04
`define CBTE_OFF_STAT     8'h08
`define CBTE_OFF_REGSEL   8'h0C
`define CBTE_OFF_REGDATA  8'h10
`define CBTE_SP_RESET     16'h00FF
`define CBTE_FLAGS_RESET  8'h00

// ****************************************************************
// Command field positions
// ****************************************************************
`define CBTE_F_OP   5:0
`define CBTE_F_RD   10:6
`define CBTE_F_RR   15:11
`define CBTE_F_BIT  18:16
`define CBTE_F_PTR  20:19

// ****************************************************************
// Status flag bit positions
// ****************************************************************
`define CBTE_C  0
`define CBTE_Z  1
`define CBTE_N  2
`define CBTE_V  3
`define CBTE_S  4
`define CBTE_H  5
`define CBTE_T  6
`define CBTE_I  7

// ****************************************************************
// Opcodes
// ****************************************************************
`define CBTE_OP_NOP    6'h00
`define CBTE_OP_ROR    6'h01
`define CBTE_OP_ASR    6'h02
`define CBTE_OP_SWAP   6'h03
`define CBTE_OP_BSET   6'h04
`define CBTE_OP_BCLR   6'h05
`define CBTE_OP_BST    6'h06
`define CBTE_OP_BLD    6'h07
`define CBTE_OP_MOV    6'h08
`define CBTE_OP_PAIR_COPY   6'h09
`define CBTE_OP_LDI    6'h0A
`define CBTE_OP_LD     6'h0B
`define CBTE_OP_LDPI   6'h0C
`define CBTE_OP_LDPD   6'h0D
`define CBTE_OP_LDD    6'h0E
`define CBTE_OP_ST     6'h0F
`define CBTE_OP_STPI   6'h10
`define CBTE_OP_STPD   6'h11
`define CBTE_OP_STD    6'h12
`define CBTE_OP_LDS    6'h13
`define CBTE_OP_STS    6'h14
`define CBTE_OP_LPM0   6'h15
`define CBTE_OP_LPM    6'h16
`define CBTE_OP_LPMPI  6'h17
`define CBTE_OP_SPM    6'h18
`define CBTE_OP_IN     6'h19
`define CBTE_OP_OUT    6'h1A
`define CBTE_OP_PUSH   6'h1B
`define CBTE_OP_POP    6'h1C
`define CBTE_OP_SLEEP  6'h1D
`define CBTE_OP_WDR    6'h1E
`define CBTE_OP_BREAK  6'h1F

// ****************************************************************
// Execution times in core cycles
// ****************************************************************
`define CBTE_CYC_ONE   8'h01
`define CBTE_CYC_MEM   8'h02
`define CBTE_CYC_CODE  8'h03
`define CBTE_CYC_SPM   8'h04

`endif

/* src/cbte_exec.v */
// Purpose: Executes bit, flag, data-transfer and control instructions.
// Assumes: Software issues one instruction at a time over AXI4-Lite.
// Notes: Register file, data, I/O and code memories live inside.
//
// How it works
// RQ1 - Rotate right through carry, old bit 0 to carry, Z C N V updated.
// RQ2 - Copy selected source bit into transfer flag, other flags untouched.
// RQ3 - Write transfer flag into selected destination bit, flags untouched.
// RQ4 - Set or clear exactly one chosen status flag in one cycle.
// RQ5 - Load at pointer, then pointer plus one, two cycles, no flags.
// RQ6 - Pointer minus one first, then load at new address, two cycles.
// RQ7 - Load at second or third pointer plus displacement, two cycles.
// RQ8 - Store at pointer, then pointer plus one, two cycles.
// RQ9 - Pointer minus one first, then store at new address, two cycles.
// RQ10 - Store at second or third pointer plus displacement, two cycles.
// RQ11 - Direct load and store at absolute address, two cycles, no flags.
// RQ12 - Code byte at third pointer into register, optional increment, 3.
// RQ13 - Push source register onto stack in two cycles, no flags.
// RQ14 - Pop top stack byte into destination in two cycles, no flags.
// RQ15 - Sleep issues in one cycle and raises a sleep request pulse.
// RQ16 - Watchdog restart in one cycle pulses the restart output.
// RQ17 - Break only signals the debug facility; one cycle here.
// RQ18 - Arithmetic shift right keeps bit 7, bit 0 to carry, Z C N V.
// RQ19 - Swap the two nibbles of the destination, no flag change.
// RQ20 - Pair copy, moves, immediates, port reads and writes: one cycle.
// RQ21 - Code write stores second:first register word at third pointer.
`timescale 1ns/10ps
`default_nettype none
`include "cbte_consts.vh"

module cbte_exec #(
	parameter DMEM_DEPTH = 256,
	parameter CMEM_WORDS = 1024
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         wdt_restart,
	output reg         sleep_req,
	output reg         break_req
);

	localparam S_IDLE = 2'b01;
	localparam S_RUN  = 2'b10;

	// ****************************************************************
	// Storage
	// ****************************************************************
	reg [7:0]  regs  [0:31];
	reg [7:0]  dmem  [0:DMEM_DEPTH-1];
	reg [7:0]  iomem [0:63];
	reg [15:0] cmem  [0:CMEM_WORDS-1];

	reg [1:0]  state;
	reg [7:0]  cnt;
	reg [5:0]  op;
	reg [4:0]  rd;
	reg [4:0]  rr;
	reg [2:0]  bsel;
	reg [1:0]  ptr;
	reg [15:0] opnd;
	reg [7:0]  flags;
	reg [15:0] sp;
	reg [4:0]  regsel;

	reg        aw_hold;
	reg        w_hold;
	reg [7:0]  awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0]  wstrb_q;

	// ****************************************************************
	// Bus handshakes and decoded write strobes
	// ****************************************************************
	wire aw_go    = s_axi_awvalid & s_axi_awready;
	wire w_go     = s_axi_wvalid & s_axi_wready;
	wire ar_go    = s_axi_arvalid & s_axi_arready;
	wire do_write = aw_hold & w_hold & ~s_axi_bvalid;
	wire idle     = state[0];
	wire wr_cmd   = do_write & (awaddr_q == `CBTE_OFF_CMD);
	wire wr_opnd  = do_write & (awaddr_q == `CBTE_OFF_OPND);
	wire wr_sel   = do_write & (awaddr_q == `CBTE_OFF_REGSEL);
	wire wr_data  = do_write & (awaddr_q == `CBTE_OFF_REGDATA);
	wire launch   = wr_cmd & idle & wstrb_q[0];
	wire finish   = state[1] & (cnt == 8'h01);

	// ****************************************************************
	// Operand fetch and address generation
	// ****************************************************************
	wire [4:0]  pidx  = 5'h1A + {2'b00, ptr, 1'b0};
	wire [15:0] pval  = {regs[pidx | 5'h01], regs[pidx]};
	wire [15:0] zval  = {regs[31], regs[30]};
	wire [7:0]  rdv   = regs[rd];
	wire [7:0]  rrv   = regs[rr];
	wire [4:0]  rd_ev = {rd[4:1], 1'b0};
	wire [4:0]  rr_ev = {rr[4:1], 1'b0};
	wire [15:0] sp_up = sp + 16'h0001;
	wire [15:0] cword = cmem[zval[10:1]];
	wire [7:0]  cbyte = zval[0] ? cword[15:8] : cword[7:0];

	// Shift results share their flag equations.
	wire [7:0] ror_res = {flags[`CBTE_C], rdv[7:1]};
	wire [7:0] asr_res = {rdv[7], rdv[7:1]};
	wire [7:0] sh_res  = (op == `CBTE_OP_ROR) ? ror_res : asr_res;

	reg [15:0] ea;

	// Effective data address: pre-decrement, displacement or direct.
	always @* begin
		case (op)
			`CBTE_OP_LDPD, `CBTE_OP_STPD: ea = pval - 16'h0001; // RQ6 RQ9
			`CBTE_OP_LDD, `CBTE_OP_STD:   ea = pval + opnd; // RQ7 RQ10
			`CBTE_OP_LDS, `CBTE_OP_STS:   ea = opnd; // RQ11
			default:                      ea = pval;
		endcase
	end

	wire [7:0] dmem_rd = dmem[ea[7:0]];

	// Cycles each instruction holds the unit busy.
	function [7:0] op_cycles;
		input [5:0] o;
		begin
			case (o)
				`CBTE_OP_LD, `CBTE_OP_LDPI, `CBTE_OP_LDPD, `CBTE_OP_LDD,
				`CBTE_OP_ST, `CBTE_OP_STPI, `CBTE_OP_STPD, `CBTE_OP_STD,
				`CBTE_OP_LDS, `CBTE_OP_STS, `CBTE_OP_PUSH,
				`CBTE_OP_POP:
					op_cycles = `CBTE_CYC_MEM;
				`CBTE_OP_LPM0, `CBTE_OP_LPM, `CBTE_OP_LPMPI:
					op_cycles = `CBTE_CYC_CODE; // RQ12
				`CBTE_OP_SPM:
					op_cycles = `CBTE_CYC_SPM; // RQ21
				default:
					op_cycles = `CBTE_CYC_ONE;
			endcase
		end
	endfunction

	// ****************************************************************
	// Sequencer
	// ****************************************************************

	// A command is taken only while idle; others are dropped.
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= S_IDLE;
			cnt   <= 8'h00;
			op    <= `CBTE_OP_NOP;
			rd    <= 5'h00;
			rr    <= 5'h00;
			bsel  <= 3'h0;
			ptr   <= 2'h0;
		end else begin
			case (state)
				S_IDLE: begin
					if (launch) begin
						state <= S_RUN;
						cnt   <= op_cycles(wdata_q[`CBTE_F_OP]);
						op    <= wdata_q[`CBTE_F_OP];
						rd    <= wdata_q[`CBTE_F_RD];
						rr    <= wdata_q[`CBTE_F_RR];
						bsel  <= wdata_q[`CBTE_F_BIT];
						ptr   <= wdata_q[`CBTE_F_PTR];
					end
				end
				S_RUN: begin
					cnt <= cnt - 8'h01;
					if (finish) begin
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Instruction effects on flags, stack pointer and side outputs
	// ****************************************************************

	// Flags and stack pointer change only in the last cycle.
	always @(posedge aclk) begin
		if (!aresetn) begin
			flags       <= `CBTE_FLAGS_RESET;
			sp          <= `CBTE_SP_RESET;
			opnd        <= 16'h0000;
			regsel      <= 5'h00;
			wdt_restart <= 1'b0;
			sleep_req   <= 1'b0;
			break_req   <= 1'b0;
		end else begin
			wdt_restart <= finish & (op == `CBTE_OP_WDR); // RQ16
			sleep_req   <= finish & (op == `CBTE_OP_SLEEP); // RQ15
			break_req   <= finish & (op == `CBTE_OP_BREAK); // RQ17
			if (wr_opnd & idle & wstrb_q[0]) begin
				opnd[7:0] <= wdata_q[7:0];
			end
			if (wr_opnd & idle & wstrb_q[1]) begin
				opnd[15:8] <= wdata_q[15:8];
			end
			if (wr_sel & wstrb_q[0]) begin
				regsel <= wdata_q[4:0];
			end
			if (finish) begin
				case (op)
					`CBTE_OP_ROR, `CBTE_OP_ASR: begin
						flags[`CBTE_C] <= rdv[0]; // RQ1 RQ18
						flags[`CBTE_Z] <= (sh_res == 8'h00);
						flags[`CBTE_N] <= sh_res[7];
						flags[`CBTE_V] <= sh_res[7] ^ rdv[0];
					end
					`CBTE_OP_BSET: flags[bsel] <= 1'b1; // RQ4
					`CBTE_OP_BCLR: flags[bsel] <= 1'b0; // RQ4
					`CBTE_OP_BST:  flags[`CBTE_T] <= rrv[bsel]; // RQ2
					`CBTE_OP_PUSH: sp <= sp - 16'h0001; // RQ13
					`CBTE_OP_POP:  sp <= sp_up; // RQ14
					default: ;
				endcase
			end
		end
	end

	// ****************************************************************
	// Register file and memory writes
	// ****************************************************************

	// The register window may be written only while the unit is idle.
	always @(posedge aclk) begin
		if (wr_data & idle & wstrb_q[0]) begin
			regs[regsel] <= wdata_q[7:0];
		end
		if (finish) begin
			case (op)
				`CBTE_OP_ROR, `CBTE_OP_ASR:
					regs[rd] <= sh_res; // RQ1 RQ18
				`CBTE_OP_SWAP:
					regs[rd] <= {rdv[3:0], rdv[7:4]}; // RQ19
				`CBTE_OP_BLD:
					regs[rd][bsel] <= flags[`CBTE_T]; // RQ3
				`CBTE_OP_MOV:
					regs[rd] <= rrv; // RQ20
				`CBTE_OP_PAIR_COPY: begin
					regs[rd_ev]         <= regs[rr_ev]; // RQ20
					regs[rd_ev | 5'h01] <= regs[rr_ev | 5'h01];
				end
				`CBTE_OP_LDI:
					regs[rd] <= opnd[7:0]; // RQ20
				`CBTE_OP_IN:
					regs[rd] <= iomem[opnd[5:0]]; // RQ20
				`CBTE_OP_OUT:
					iomem[opnd[5:0]] <= rrv; // RQ20
				`CBTE_OP_LD, `CBTE_OP_LDD, `CBTE_OP_LDS:
					regs[rd] <= dmem_rd; // RQ7 RQ11
				`CBTE_OP_LDPI, `CBTE_OP_LDPD: begin
					regs[rd] <= dmem_rd; // RQ5 RQ6
					{regs[pidx | 5'h01], regs[pidx]} <=
						(op == `CBTE_OP_LDPI) ? pval + 16'h0001 : ea;
				end
				`CBTE_OP_ST, `CBTE_OP_STD, `CBTE_OP_STS:
					dmem[ea[7:0]] <= rrv; // RQ10 RQ11
				`CBTE_OP_STPI, `CBTE_OP_STPD: begin
					dmem[ea[7:0]] <= rrv; // RQ8 RQ9
					{regs[pidx | 5'h01], regs[pidx]} <=
						(op == `CBTE_OP_STPI) ? pval + 16'h0001 : ea;
				end
				`CBTE_OP_LPM0:
					regs[0] <= cbyte; // RQ12
				`CBTE_OP_LPM:
					regs[rd] <= cbyte; // RQ12
				`CBTE_OP_LPMPI: begin
					regs[rd] <= cbyte; // RQ12
					{regs[31], regs[30]} <= zval + 16'h0001;
				end
				`CBTE_OP_SPM:
					cmem[zval[10:1]] <= {regs[1], regs[0]}; // RQ21
				`CBTE_OP_PUSH:
					dmem[sp[7:0]] <= rrv; // RQ13
				`CBTE_OP_POP:
					regs[rd] <= dmem[sp_up[7:0]]; // RQ14
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// AXI4-Lite write channels
	// ****************************************************************

	// Address and data are held until both are in, then answered.
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold       <= 1'b0;
			w_hold        <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= do_write | ~(aw_hold | aw_go);
			s_axi_wready  <= do_write | ~(w_hold | w_go);
			if (aw_go) begin
				aw_hold  <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_hold <= 1'b0;
			end
			if (w_go) begin
				w_hold  <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_hold <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				if (wr_cmd | wr_opnd | wr_sel | wr_data) begin
					s_axi_bresp <= 2'b00;
				end else if (awaddr_q == `CBTE_OFF_STAT) begin
					s_axi_bresp <= 2'b00;
				end else begin
					s_axi_bresp <= 2'b10;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channels
	// ****************************************************************

	// Read data is registered one cycle after the address is taken.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= (s_axi_rvalid & s_axi_rready) |
				(~s_axi_rvalid & ~ar_go);
			if (ar_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				if (s_axi_araddr == `CBTE_OFF_CMD) begin
					s_axi_rdata <= {11'h000, ptr, bsel, rr, rd, op};
				end else if (s_axi_araddr == `CBTE_OFF_OPND) begin
					s_axi_rdata <= {16'h0000, opnd};
				end else if (s_axi_araddr == `CBTE_OFF_STAT) begin
					s_axi_rdata <= {sp, flags, 7'h00, state[1]};
				end else if (s_axi_araddr == `CBTE_OFF_REGSEL) begin
					s_axi_rdata <= {27'h0000000, regsel};
				end else if (s_axi_araddr == `CBTE_OFF_REGDATA) begin
					s_axi_rdata <= {24'h000000, regs[regsel]};
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'b10;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

/* test/cbte_exec_sva.sv */
// Purpose: Port-level checks for the bit, flag and transfer unit.
// Assumes: Bound to the top module; one clock, synchronous low reset.
// Notes: Control pulses are timed from the write response of a command.
`timescale 1ns/10ps
`default_nettype none
`include "cbte_consts.vh"

module cbte_exec_sva (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        wdt_restart,
	input wire logic        sleep_req,
	input wire logic        break_req
);
	logic [5:0] last_op;
	logic       last_cmd;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ****************************************************************
	// Helper logic
	// ****************************************************************
	// Remembers target and opcode of the most recently taken write.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_op  <= 6'h00;
			last_cmd <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				last_cmd <= (s_axi_awaddr == `CBTE_OFF_CMD);
			end
			if (s_axi_wvalid && s_axi_wready) begin
				last_op <= s_axi_wdata[5:0];
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_wdt_one_pulse: assert property (
		$rose(s_axi_bvalid) && last_cmd && last_op == `CBTE_OP_WDR
		|-> ##1 wdt_restart ##1 !wdt_restart)
		else $error("watchdog restart pulse late or too long");
	a_sleep_one_pulse: assert property (
		$rose(s_axi_bvalid) && last_cmd && last_op == `CBTE_OP_SLEEP
		|-> ##1 sleep_req ##1 !sleep_req)
		else $error("sleep request pulse late or too long");
	a_break_one_pulse: assert property (
		$rose(s_axi_bvalid) && last_cmd && last_op == `CBTE_OP_BREAK
		|-> ##1 break_req ##1 !break_req)
		else $error("break pulse late or too long");
	a_wdt_needs_cmd: assert property (
		$rose(wdt_restart) |-> last_cmd && last_op == `CBTE_OP_WDR)
		else $error("watchdog restart without its command");
	a_pulses_apart: assert property (
		sleep_req |-> !wdt_restart && !break_req)
		else $error("two control pulses at once");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after the transfer");
	a_bresp_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before it was taken");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not one cycle after the address");
	a_rdata_holds: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before it was taken");
	a_unmapped_err: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr > `CBTE_OFF_REGDATA
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");

	// Main scenarios reached.
	c_wdt: cover property (wdt_restart);
	c_sleep: cover property (sleep_req);
	c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
`default_nettype wire

/* test/test_cpu_bitflag_transfer_exec.sv */
// Purpose: Self-checking bench for the bit, flag and transfer unit.
// Assumes: Register window, status and command registers over AXI4-Lite.
// Notes: Random data from a fixed seed; expectations come from models here.
`timescale 1ns/10ps
`default_nettype none
`include "cbte_consts.vh"

module test_cpu_bitflag_transfer_exec;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire logic   s_axi_arready, s_axi_rvalid;
	wire logic   wdt_restart, sleep_req, break_req;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	int          n_mismatch = 0;
	int          checked = 0;

	cbte_exec uut (.*);

	// Free-running core clock.
	always #12.5 aclk = ~aclk;

	// ****************************************************************
	// Bus tasks and models
	// ****************************************************************
	task automatic wrap_up();
		$display("Checks made: %0d, mismatches: %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int t = 0; t < 64; t++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
		end
		n_mismatch++;
		wrap_up();
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int t = 0; t < 64; t++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				return;
			end
		end
		n_mismatch++;
		wrap_up();
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
	endtask

	// Starts one instruction and waits for busy to clear.
	// Only code-memory instructions outlast the first status read.
	task automatic ex(input logic [31:0] c);
		logic [31:0] d;
		logic [1:0] r;
		logic lng;
		lng = c[5:0] >= `CBTE_OP_LPM0 && c[5:0] <= `CBTE_OP_SPM;
		w(`CBTE_OFF_CMD, c);
		for (int t = 0; t < 20; t++) begin
			rd(`CBTE_OFF_STAT, d, r);
			if (t == 0) chk({31'h0, d[0]}, {31'h0, lng});
			if (d[0] === 1'b0) return;
		end
		n_mismatch++;
		wrap_up();
	endtask

	task automatic sr(input logic [4:0] i, input logic [7:0] v);
		w(`CBTE_OFF_REGSEL, {27'h0, i});
		w(`CBTE_OFF_REGDATA, {24'h0, v});
	endtask

	task automatic gr(input logic [4:0] i, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		w(`CBTE_OFF_REGSEL, {27'h0, i});
		rd(`CBTE_OFF_REGDATA, d, r);
		chk({24'h0, d[7:0]}, {24'h0, e});
	endtask

	task automatic st(input logic [7:0] f, input logic [15:0] p);
		logic [31:0] d;
		logic [1:0] r;
		rd(`CBTE_OFF_STAT, d, r);
		chk({d[31:8], 8'h00}, {p, f, 8'h00});
	endtask

	function automatic logic [31:0] cm(input logic [5:0] o,
		input logic [4:0] d, input logic [4:0] s, input logic [2:0] b,
		input logic [1:0] p);
		return {11'h000, p, b, s, d, o};
	endfunction

	// Shift model: bit 0 to carry, Z N V updated, other flags kept.
	function automatic logic [15:0] shf(input logic [5:0] o,
		input logic [7:0] v, input logic [7:0] f);
		logic [7:0] r;
		r = (o == `CBTE_OP_ROR) ? {f[0], v[7:1]} : {v[7], v[7:1]};
		f[0] = v[0];
		f[1] = (r == 8'h00);
		f[2] = r[7];
		f[3] = r[7] ^ v[0];
		return {f, r};
	endfunction

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [31:0] x, d;
		logic [15:0] e;
		logic [7:0] v, u, ef;
		logic [5:0] o;
		logic [1:0] r;
		void'($urandom(8110));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`CBTE_OFF_STAT, d, r);
		chk(d, 32'h00FF0000);
		ef = 8'h00;
		for (int i = 0; i < 16; i++) begin
			o = (i < 8) ? `CBTE_OP_BSET : `CBTE_OP_BCLR;
			ex(cm(o, 5'h00, 5'h00, i[2:0], 2'h0));
			ef[i[2:0]] = (i < 8);
			st(ef, 16'h00FF);
		end
		for (int i = 0; i < 12; i++) begin
			x = $urandom;
			o = (i % 3 == 0) ? `CBTE_OP_ROR :
				(i % 3 == 1) ? `CBTE_OP_ASR : `CBTE_OP_SWAP;
			v = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : x[7:0];
			ef[0] = (i < 2) ? 1'b0 : x[8];
			ex(cm(ef[0] ? `CBTE_OP_BSET : `CBTE_OP_BCLR, 5'h00, 5'h00,
				3'h0, 2'h0));
			sr(5'h05, v);
			ex(cm(o, 5'h05, 5'h00, 3'h0, 2'h0));
			e = (o == `CBTE_OP_SWAP) ? {ef, v[3:0], v[7:4]} : shf(o, v, ef);
			ef = e[15:8];
			gr(5'h05, e[7:0]);
			st(ef, 16'h00FF);
		end
		for (int i = 0; i < 4; i++) begin
			x = $urandom;
			sr(5'h03, x[7:0]);
			ex(cm(`CBTE_OP_BST, 5'h00, 5'h03, x[10:8], 2'h0));
			ef[6] = x[x[10:8]];
			st(ef, 16'h00FF);
			sr(5'h04, x[23:16]);
			ex(cm(`CBTE_OP_BLD, 5'h04, 5'h00, x[10:8], 2'h0));
			v = x[23:16];
			v[x[10:8]] = ef[6];
			gr(5'h04, v);
			st(ef, 16'h00FF);
		end
		x = $urandom;
		v = x[7:0];
		u = ~x[7:0];
		sr(5'h0A, v);
		sr(5'd26, 8'h70);
		sr(5'd27, 8'h00);
		sr(5'd28, 8'h40);
		sr(5'd29, 8'h00);
		sr(5'd30, 8'h50);
		sr(5'd31, 8'h00);
		ex(cm(`CBTE_OP_STPI, 5'h00, 5'h0A, 3'h0, 2'h1));
		gr(5'd28, 8'h41);
		ex(cm(`CBTE_OP_LDPD, 5'h0B, 5'h00, 3'h0, 2'h1));
		gr(5'd28, 8'h40);
		gr(5'h0B, v);
		w(`CBTE_OFF_OPND, 32'h5);
		ex(cm(`CBTE_OP_STD, 5'h00, 5'h0A, 3'h0, 2'h2));
		gr(5'd30, 8'h50);
		w(`CBTE_OFF_OPND, 32'h55);
		ex(cm(`CBTE_OP_LDS, 5'h0C, 5'h00, 3'h0, 2'h0));
		gr(5'h0C, v);
		sr(5'h0A, u);
		w(`CBTE_OFF_OPND, 32'h60);
		ex(cm(`CBTE_OP_STS, 5'h00, 5'h0A, 3'h0, 2'h0));
		w(`CBTE_OFF_OPND, 32'h20);
		ex(cm(`CBTE_OP_LDD, 5'h0D, 5'h00, 3'h0, 2'h1));
		gr(5'h0D, u);
		gr(5'd28, 8'h40);
		ex(cm(`CBTE_OP_STPD, 5'h00, 5'h0A, 3'h0, 2'h0));
		gr(5'd26, 8'h6F);
		ex(cm(`CBTE_OP_LDPI, 5'h0E, 5'h00, 3'h0, 2'h0));
		gr(5'h0E, u);
		gr(5'd26, 8'h70);
		ex(cm(`CBTE_OP_ST, 5'h00, 5'h0B, 3'h0, 2'h0));
		ex(cm(`CBTE_OP_LD, 5'h15, 5'h00, 3'h0, 2'h0));
		gr(5'h15, v);
		gr(5'd26, 8'h70);
		ex(cm(`CBTE_OP_PUSH, 5'h00, 5'h0A, 3'h0, 2'h0));
		st(ef, 16'h00FE);
		ex(cm(`CBTE_OP_POP, 5'h0F, 5'h00, 3'h0, 2'h0));
		gr(5'h0F, u);
		st(ef, 16'h00FF);
		ex(cm(`CBTE_OP_PAIR_COPY, 5'h10, 5'h0A, 3'h0, 2'h0));
		gr(5'h10, u);
		gr(5'h11, v);
		w(`CBTE_OFF_OPND, 32'hA5);
		ex(cm(`CBTE_OP_LDI, 5'h12, 5'h00, 3'h0, 2'h0));
		gr(5'h12, 8'hA5);
		w(`CBTE_OFF_OPND, 32'h07);
		ex(cm(`CBTE_OP_OUT, 5'h00, 5'h0B, 3'h0, 2'h0));
		ex(cm(`CBTE_OP_IN, 5'h13, 5'h00, 3'h0, 2'h0));
		gr(5'h13, v);
		ex(cm(`CBTE_OP_MOV, 5'h14, 5'h0A, 3'h0, 2'h0));
		gr(5'h14, u);
		sr(5'h00, v);
		sr(5'h01, u);
		sr(5'd30, 8'h06);
		ex(cm(`CBTE_OP_SPM, 5'h00, 5'h00, 3'h0, 2'h2));
		sr(5'h00, u);
		ex(cm(`CBTE_OP_LPM0, 5'h00, 5'h00, 3'h0, 2'h2));
		gr(5'h00, v);
		ex(cm(`CBTE_OP_LPMPI, 5'h02, 5'h00, 3'h0, 2'h2));
		gr(5'h02, v);
		gr(5'd30, 8'h07);
		ex(cm(`CBTE_OP_LPM, 5'h03, 5'h00, 3'h0, 2'h2));
		gr(5'h03, u);
		st(ef, 16'h00FF);
		ex(cm(`CBTE_OP_WDR, 5'h00, 5'h00, 3'h0, 2'h0));
		ex(cm(`CBTE_OP_SLEEP, 5'h00, 5'h00, 3'h0, 2'h0));
		ex(cm(`CBTE_OP_BREAK, 5'h00, 5'h00, 3'h0, 2'h0));
		st(ef, 16'h00FF);
		rd(8'h14, d, r);
		chk(d, 32'h00000000);
		chk({30'h0, r}, 32'h00000002);
		wr(8'h1C, 32'h0, r);
		chk({30'h0, r}, 32'h00000002);
		wrap_up();
	end
endmodule

bind cbte_exec cbte_exec_sva chk (.*);
`default_nettype wire
